// >>> rtl/dlms_pkg.sv
// Constants and helpers for the dual link mode selector
// Notes on behaviour
// - Pixel clocks up to 165 MHz travel on the primary link only, bar deep colour low bits.
// - Pixel clocks above 165 MHz use both links together.
// - In dual mode each link runs at exactly half the pixel clock.
// - In dual mode the secondary link never runs below 82.5 MHz; deep colour is refused in dual mode.
// - After boot only the primary link is active.
// - Secondary link starts only for a supported, requested format above 165 MHz or with deep colour.
// - Single link stays at or below 165 MHz; primary supports 165 MHz.
// - Single mode covers 25 to 165 MHz; primary above 165 only past 330.
// - Parts with formats above 165 MHz carry the secondary link too.
// - Sender switches freely between single and dual link formats; the code refuses any request while a dual pair is half taken.
// - When only one link is driven the secondary is held inactive.
// - Colour depth above 24 bits may use the secondary link.
// - Deep colour: high bits on primary, low bits on secondary.
// - Secondary link uses the same MSB aligned 24-bit RGB layout.
// - Deep colour only when the monitor supports it, else 24 bits.
// - No format beyond the least capable controller, transmitter, monitor.
// - Both links share one link clock, splitting bandwidth evenly.
package dlms_pkg;
    localparam int KHZ_W = 20;
    localparam logic [19:0] CROSS_KHZ = 20'h28488;
    localparam logic [19:0] DUAL_TOP_KHZ = 20'h50910;
    localparam logic [19:0] SEC_MIN_KHZ = 20'h14244;
    localparam logic [19:0] MIN_KHZ = 20'h061a8;
    localparam logic [19:0] BOOT_KHZ = 20'h06257;
    localparam int PIX_W = 48;
    localparam int LNK_W = 24;
    localparam int WORD_W = 2 + 2 * PIX_W;
    localparam int FIFO_DEPTH = 8;

    // Upper byte of each 16-bit component, MSB aligned RGB
    function automatic logic [23:0] msb8(input logic [47:0] p);
        return {p[47:40], p[31:24], p[15:8]};
    endfunction

    // Lower byte of each component for the deep colour half
    function automatic logic [23:0] lsb8(input logic [47:0] p);
        return {p[39:32], p[23:16], p[7:0]};
    endfunction
endpackage

// >>> rtl/dlms_top.sv
// Link mode selector with pixel FIFO crossing into the link clock
`timescale 1ns/10ps
`default_nettype none

module dlms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic wr_room,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] s1;
        logic [AW:0] s2;
        logic room;
    } dlms_side_t;

    logic [WIDTH-1:0] mem [DEPTH];
    dlms_side_t w_q, w_d, r_q, r_d;
    logic [AW:0] wcnt;
    logic [AW:0] rbin_w;
    logic [AW:0] wbin_r;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    assign rbin_w = g2b(w_q.s2);
    assign wbin_r = g2b(r_q.s2);
    assign wcnt = w_q.bin - rbin_w;
    assign wr_ready = (wcnt != (AW+1)'(DEPTH));
    assign wr_room = w_q.room;
    assign rd_valid = (r_q.bin != wbin_r);
    assign rd_data = mem[r_q.bin[AW-1:0]];

    always_comb begin
        w_d = w_q;
        w_d.s1 = r_q.gray;
        w_d.s2 = w_q.s1;
        if (wr_valid && wr_ready) begin
            w_d.bin = w_q.bin + 1'b1;
        end
        w_d.gray = w_d.bin ^ (w_d.bin >> 1);
        // Two free slots, since the writer sees this one cycle late
        w_d.room = ((w_d.bin - rbin_w) <= (AW+1)'(DEPTH - 2));
    end

    always_comb begin
        r_d = r_q;
        r_d.s1 = w_q.gray;
        r_d.s2 = r_q.s1;
        if (rd_valid && rd_ready) begin
            r_d.bin = r_q.bin + 1'b1;
        end
        r_d.gray = r_d.bin ^ (r_d.bin >> 1);
        r_d.room = 1'b0;
    end

    always_ff @(posedge wr_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            w_q <= '0;
        end else begin
            w_q <= w_d;
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) begin
            mem[w_q.bin[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge rd_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // Room must stay pessimistic, or a pixel would meet a full memory
    room_bound_a: assert property (@(posedge wr_clk) disable iff (!wr_rst_n)
        wr_room |-> wcnt <= (AW+1)'(DEPTH - 2))
        else $error("fifo room flag too optimistic");
    write_gray_a: assert property (@(posedge wr_clk) disable iff (!wr_rst_n)
        $countones(w_q.gray ^ $past(w_q.gray)) <= 1)
        else $error("write pointer code moved more than one bit");
    read_gray_a: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
        $countones(r_q.gray ^ $past(r_q.gray)) <= 1)
        else $error("read pointer code moved more than one bit");
endmodule

module dlms_top #(
    parameter bit DUAL_CAP = 1'b1,
    parameter bit DEEP_CAP = 1'b1,
    parameter logic [19:0] SYS_MAX_KHZ = 20'h50910
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic [19:0] req_khz,
    input wire logic req_deep,
    input wire logic mon_dual_ok,
    input wire logic mon_deep_ok,
    input wire logic [19:0] mon_max_khz,
    input wire logic [19:0] tx_max_khz,
    output logic req_ack,
    output logic req_nak,
    output logic mode_dual,
    output logic mode_deep,
    input wire logic pix_valid,
    input wire logic [47:0] pix_data,
    output logic pix_ready,
    input wire logic link_clk,
    output logic [23:0] l0_data,
    output logic [23:0] l1_data,
    output logic l0_de,
    output logic l1_de,
    output logic l0_on,
    output logic l1_on
);
    typedef struct packed {
        logic dual;
        logic deep;
        logic [19:0] khz;
        logic ack;
        logic nak;
        logic half;
        logic [47:0] hold;
    } dlms_sys_t;

    typedef struct packed {
        logic [1:0] rst;
        logic [23:0] d0;
        logic [23:0] d1;
        logic de0;
        logic de1;
        logic on0;
        logic on1;
    } dlms_lnk_t;

    dlms_sys_t s_q, s_d;
    dlms_lnk_t k_q, k_d;
    logic lrst_n;
    logic push;
    logic wr_ready;
    logic [dlms_pkg::WORD_W-1:0] wword;
    logic rd_valid;
    logic [dlms_pkg::WORD_W-1:0] rword;
    logic need_dual;
    logic [19:0] sys_max;
    logic fmt_ok;
    logic pix_fire;

    // A single link part is capped at the crossover
    assign sys_max = DUAL_CAP ? SYS_MAX_KHZ : dlms_pkg::CROSS_KHZ;
    assign need_dual = req_khz > dlms_pkg::CROSS_KHZ;
    assign fmt_ok = req_khz >= dlms_pkg::MIN_KHZ
        && req_khz <= sys_max && req_khz <= mon_max_khz
        && req_khz <= tx_max_khz
        && (!need_dual || (DUAL_CAP && mon_dual_ok))
        && (!req_deep || (DEEP_CAP && mon_deep_ok && !need_dual))
        && !s_q.half
        // A pair's first pixel taken now must not meet a mode switch
        && !(pix_fire && s_q.dual && !s_q.half);
    assign pix_fire = pix_valid && pix_ready;
    // Dual words carry a pixel pair, so each link runs at half rate
    assign push = pix_fire && (!s_q.dual || s_q.half);
    assign wword = s_q.dual ? {1'b1, s_q.deep, s_q.hold, pix_data}
                            : {1'b0, s_q.deep, pix_data, 48'h0};

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.nak = 1'b0;
        if (req_valid) begin
            if (fmt_ok) begin
                // Mode bits only move here, at an accepted format switch
                s_d.dual = need_dual;
                s_d.deep = req_deep;
                s_d.khz = req_khz;
                s_d.ack = 1'b1;
            end else begin
                s_d.nak = 1'b1;
            end
        end
        if (pix_fire) begin
            if (s_q.dual && !s_q.half) begin
                s_d.hold = pix_data;
                s_d.half = 1'b1;
            end else begin
                s_d.half = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.khz <= dlms_pkg::BOOT_KHZ;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ack = s_q.ack;
    assign req_nak = s_q.nak;
    assign mode_dual = s_q.dual;
    assign mode_deep = s_q.deep;

    dlms_fifo #(
        .WIDTH(dlms_pkg::WORD_W),
        .DEPTH(dlms_pkg::FIFO_DEPTH)
    ) u_fifo (
        .wr_clk(clk),
        .wr_rst_n(arst_n),
        .wr_valid(push),
        .wr_ready(wr_ready),
        .wr_room(pix_ready),
        .wr_data(wword),
        .rd_clk(link_clk),
        .rd_rst_n(lrst_n),
        .rd_valid(rd_valid),
        .rd_ready(1'b1),
        .rd_data(rword)
    );

    // Reset leaves the link domain on its own clock edge
    assign lrst_n = k_q.rst[1];

    always_comb begin
        k_d = k_q;
        k_d.rst = {k_q.rst[0], 1'b1};
        k_d.on0 = 1'b1;
        k_d.d0 = '0;
        k_d.d1 = '0;
        k_d.de0 = 1'b0;
        k_d.de1 = 1'b0;
        if (rd_valid && lrst_n) begin
            // Both lanes leave on one link clock edge
            k_d.d0 = dlms_pkg::msb8(rword[95:48]);
            k_d.de0 = 1'b1;
            k_d.on1 = rword[97] || rword[96];
            k_d.de1 = k_d.on1;
            if (rword[97]) begin
                k_d.d1 = dlms_pkg::msb8(rword[47:0]);
            end else if (rword[96]) begin
                k_d.d1 = dlms_pkg::lsb8(rword[95:48]);
            end
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            k_q <= '0;
        end else begin
            k_q <= k_d;
        end
    end

    assign l0_data = k_q.d0;
    assign l1_data = k_q.d1;
    assign l0_de = k_q.de0;
    assign l1_de = k_q.de1;
    assign l0_on = k_q.on0;
    assign l1_on = k_q.on1;

    dual_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_q.dual) |-> $past(req_valid && req_khz > dlms_pkg::CROSS_KHZ
            && mon_dual_ok))
        else $error("dual mode without a valid request");
    mode_switch_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.dual != $past(s_q.dual)) |-> s_q.ack)
        else $error("link mode moved without a format switch");
    dual_above_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.dual |-> s_q.khz > dlms_pkg::CROSS_KHZ)
        else $error("dual mode at or below crossover");
    single_below_a: assert property (@(posedge clk) disable iff (!arst_n)
        !s_q.dual |-> s_q.khz <= dlms_pkg::CROSS_KHZ)
        else $error("single mode above crossover");
    sec_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.dual |-> (s_q.khz >> 1) >= dlms_pkg::SEC_MIN_KHZ)
        else $error("secondary link below minimum rate");
    cap_limit_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.ack |-> $past(req_khz <= mon_max_khz && req_khz <= tx_max_khz)
            && s_q.khz >= dlms_pkg::MIN_KHZ)
        else $error("accepted format beyond capability");
    deep_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(s_q.deep) |-> $past(mon_deep_ok) && !s_q.dual)
        else $error("deep colour without monitor support");
    sec_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        !k_q.on1 |-> !k_q.de1 && k_q.d1 == 24'h0)
        else $error("secondary link active while off");
    lanes_even_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        k_q.de1 |-> k_q.de0)
        else $error("secondary lane without primary");
    deep_split_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (rd_valid && !rword[97] && rword[96]) |=>
            k_q.d1 == dlms_pkg::lsb8($past(rword[95:48])))
        else $error("deep colour low bits misplaced");
    primary_on_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        k_q.on0)
        else $error("primary link inactive out of reset");
    primary_word_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        rd_valid |=> k_q.de0 && k_q.d0 == dlms_pkg::msb8($past(rword[95:48])))
        else $error("primary lane word wrong");
    lane_zero_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        !k_q.de0 |-> k_q.d0 == 24'h0)
        else $error("primary lane data while idle");
    dual_pair_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (rd_valid && rword[97]) |=> k_q.de1 && k_q.d1 == dlms_pkg::msb8($past(rword[47:0])))
        else $error("second pixel of pair not on secondary lane");
    deep_lane_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (rd_valid && rword[96]) |=> k_q.de1 && k_q.on1)
        else $error("deep colour low bits not sent");
    sec_follow_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        (rd_valid && !rword[97] && !rword[96]) |=> !k_q.on1 && !k_q.de1)
        else $error("secondary link left active in single mode");

    req_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
        $past(req_valid) |-> s_q.ack != s_q.nak)
        else $error("request without exactly one answer");
    answer_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.ack || s_q.nak) |-> $past(req_valid))
        else $error("answer without a request");
    format_take_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.ack |-> s_q.khz == $past(req_khz))
        else $error("accepted format not the requested one");
    nak_keeps_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.nak |-> $stable(s_q.dual) && $stable(s_q.deep))
        else $error("refused request changed the mode");
    khz_move_a: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(s_q.khz) |-> s_q.ack)
        else $error("pixel clock moved without a format switch");
    half_dual_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.half |-> s_q.dual)
        else $error("held pixel outside dual mode");
    deep_single_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.deep |-> !s_q.dual)
        else $error("deep colour in dual mode");
    dual_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.dual |-> DUAL_CAP)
        else $error("dual mode on a single link part");
    push_room_a: assert property (@(posedge clk) disable iff (!arst_n)
        push |-> wr_ready)
        else $error("pixel word pushed into a full fifo");

    dual_ack_c: cover property (@(posedge clk) disable iff (!arst_n)
        s_q.ack && s_q.dual);
    deep_ack_c: cover property (@(posedge clk) disable iff (!arst_n)
        s_q.ack && s_q.deep);
    nak_c: cover property (@(posedge clk) disable iff (!arst_n) s_q.nak);
    full_c: cover property (@(posedge clk) disable iff (!arst_n) !wr_ready);
    both_lanes_c: cover property (@(posedge link_clk) disable iff (!lrst_n)
        k_q.de0 && k_q.de1);
endmodule

`default_nettype wire

// >>> rtl/dlms_dummy_guard.sv
// Spare design unit: holds no logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> testbench/dlms_mon_model.sv
// Monitor receiver model: collects lane words per link as they arrive
`timescale 1ns/10ps
`default_nettype none

module dlms_mon_model (
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic [23:0] l0_data,
    input wire logic [23:0] l1_data,
    input wire logic l0_de,
    input wire logic l1_de,
    input wire logic l0_on,
    input wire logic l1_on
);
    logic [23:0] q0[$];
    logic [23:0] q1[$];
    // Lane 0 needs l0_on and l0_de, lane 1 only l1_de, so a dual word needs both lanes live
    // Sampled mid-cycle so the lane outputs have settled
    always @(negedge link_clk) begin
        if (arst_n && l0_on && l0_de) begin
            q0.push_back(l0_data);
        end
        if (arst_n && l1_de) begin
            q1.push_back(l1_data);
        end
    end
endmodule
`default_nettype wire

// >>> testbench/test_dual_link_mode_selector.sv
// Self-checking bench for the link mode selector
`timescale 1ns/10ps
`default_nettype none

module test_dual_link_mode_selector;
    logic clk = 0, link_clk = 0, arst_n = 0, req_valid = 0, req_deep = 0;
    logic mon_dual_ok = 1, mon_deep_ok = 1, pix_valid = 0;
    logic [19:0] req_khz = 20'h0, mon_max_khz = 20'h50910, tx_max_khz = 20'h50910;
    logic [47:0] pix_data = 48'h0;
    wire logic req_ack, req_nak, mode_dual, mode_deep, pix_ready, l0_de, l1_de, l0_on, l1_on;
    wire logic [23:0] l0_data, l1_data;
    int err_count = 0, total_checks = 0, stalls = 0, k;
    logic [31:0] lfsr = 32'h160f;
    logic [23:0] e0[$], e1[$];
    logic cur_dual = 0, cur_deep = 0, odd_px = 0;
    logic [19:0] khz_t[6] = '{20'h061a7, 20'h061a8, 20'h28488, 20'h28489, 20'h50911, 20'h50910};
    logic deep_t[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    dlms_top dlms_top_i (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_khz(req_khz),
        .req_deep(req_deep), .mon_dual_ok(mon_dual_ok), .mon_deep_ok(mon_deep_ok),
        .mon_max_khz(mon_max_khz), .tx_max_khz(tx_max_khz), .req_ack(req_ack), .req_nak(req_nak),
        .mode_dual(mode_dual), .mode_deep(mode_deep), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_ready(pix_ready), .link_clk(link_clk), .l0_data(l0_data), .l1_data(l1_data),
        .l0_de(l0_de), .l1_de(l1_de), .l0_on(l0_on), .l1_on(l1_on));
    dlms_mon_model dlms_mon_model_i (.link_clk(link_clk), .arst_n(arst_n), .l0_data(l0_data),
        .l1_data(l1_data), .l0_de(l0_de), .l1_de(l1_de), .l0_on(l0_on), .l1_on(l1_on));

    initial begin
        forever #4 clk = ~clk;
    end
    // Odd start offset keeps the link clock out of phase with clk
    initial begin
        #1.3;
        forever #7.5 link_clk = ~link_clk;
    end

    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [23:0] hi8(input logic [47:0] p);
        return {p[47:40], p[31:24], p[15:8]};
    endfunction
    function automatic logic [23:0] lo8(input logic [47:0] p);
        return {p[39:32], p[23:16], p[7:0]};
    endfunction
    function automatic logic exp_ok(input logic [19:0] f, input logic d);
        logic [19:0] lim;
        lim = (mon_max_khz < tx_max_khz) ? mon_max_khz : tx_max_khz;
        lim = (lim < 20'h50910) ? lim : 20'h50910;
        // Dual implies f/2 above 82.5 MHz, so the secondary never runs slower
        if (f < 20'h061a8 || f > lim) return 1'b0;
        if (f > 20'h28488 && !mon_dual_ok) return 1'b0;
        if (d && (!mon_deep_ok || f > 20'h28488)) return 1'b0;
        return 1'b1;
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic req(input logic [19:0] f, input logic d, input logic held);
        logic ok;
        @(negedge clk);
        req_valid = 1;
        req_khz = f;
        req_deep = d;
        ok = exp_ok(f, d) && !held;
        @(negedge clk);
        req_valid = 0;
        check({req_ack, req_nak}, ok ? 2'b10 : 2'b01, "request answer");
        if (ok) begin
            cur_dual = f > 20'h28488;
            cur_deep = d;
        end
        check({mode_dual, mode_deep}, {cur_dual, cur_deep}, "mode");
    endtask

    task automatic send(input int n);
        int i;
        logic [47:0] p;
        i = 0;
        while (i < n) begin
            @(negedge clk);
            if (pix_ready === 1'b1) begin
                lfsr = nx(lfsr);
                p = {lfsr, lfsr[31:16] ^ 16'h5a3c};
                pix_valid = 1;
                pix_data = p;
                // Pair parity runs across calls, since a held pixel waits for the next
                if (cur_dual && odd_px) e1.push_back(hi8(p));
                else e0.push_back(hi8(p));
                if (cur_dual) odd_px = !odd_px;
                if (cur_deep) e1.push_back(lo8(p));
                i++;
            end else begin
                pix_valid = 0;
                stalls++;
            end
        end
        @(negedge clk);
        pix_valid = 0;
    endtask

    task automatic drain(input string name);
        repeat (60) @(negedge clk);
        check(dlms_mon_model_i.q0.size(), e0.size(), "lane0 count");
        check(dlms_mon_model_i.q1.size(), e1.size(), "lane1 count");
        foreach (e0[i]) if (i < dlms_mon_model_i.q0.size())
            check(dlms_mon_model_i.q0[i], e0[i], "lane0");
        foreach (e1[i]) if (i < dlms_mon_model_i.q1.size())
            check(dlms_mon_model_i.q1[i], e1[i], "lane1");
        if (!cur_deep) check(l1_on, cur_dual, "secondary activity");
        dlms_mon_model_i.q0.delete();
        dlms_mon_model_i.q1.delete();
        e0.delete();
        e1.delete();
        $display("test %s done", name);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1;
        check({mode_dual, l1_on}, 2'b00, "boot mode");
        repeat (4) @(negedge clk);
        check(l0_on, 1'b1, "primary on at boot");
        send(12);
        drain("boot single");
        for (k = 0; k < 6; k++) req(khz_t[k], deep_t[k], 1'b0);
        send(10);
        drain("dual");
        send(1);
        req(20'h186a0, 1'b0, 1'b1);
        send(1);
        drain("held pair");
        req(20'h186a0, 1'b1, 1'b0);
        stalls = 0;
        send(20);
        check(stalls > 0, 1'b1, "fifo refused");
        drain("deep");
        mon_deep_ok = 0;
        req(20'h186a0, 1'b1, 1'b0);
        mon_dual_ok = 0;
        req(20'h30d40, 1'b0, 1'b0);
        mon_dual_ok = 1;
        mon_max_khz = 20'h249f0;
        req(20'h27100, 1'b0, 1'b0);
        mon_max_khz = 20'h50910;
        tx_max_khz = 20'h249f0;
        req(20'h249f0, 1'b0, 1'b0);
        tx_max_khz = 20'h50910;
        mon_deep_ok = 1;
        for (k = 0; k < 10; k++) begin
            lfsr = nx(lfsr);
            req(20'(lfsr[18:0]), lfsr[19] & lfsr[3], 1'b0);
        end
        send(8);
        drain("random formats");
        arst_n = 0;
        repeat (3) @(negedge clk);
        check({mode_dual, mode_deep, l1_on}, 3'b000, "mid reset");
        arst_n = 1;
        repeat (4) @(negedge clk);
        check({l0_on, pix_ready, mode_dual}, 3'b110, "after mid reset");
        complete_run();
    end
endmodule
`default_nettype wire
